// File: include/macrocell_regs.vh
`ifndef MACROCELL_REGS_VH
`define MACROCELL_REGS_VH

// array geometry
`define MACROCELLS 24
`define FLOPS 48
`define DED_INPUTS 14
`define LOGIC_PINS 38
`define ARRAY_INPUTS 86
`define TERM_WIDTH 172
`define TERMS_PER_MC 17
`define SUM_TERM_PTS 4
`define MAX_SUM_PTS 12
`define PRESET_TERMS 8
`define TERM_COUNT 416
`define TERM_LAST 9'h19f
`define PRESET_BASE 408

// product term slots inside one macrocell
`define PT_AR1 12
`define PT_CK1 13
`define PT_CK2 14
`define PT_AR2 15
`define PT_OE 16

// per-macrocell configuration bits
`define CFG_COMBINE 0
`define CFG_BYPASS 1
`define CFG_COMBOUT 2
`define CFG_POLARITY 3
`define CFG_T1 4
`define CFG_T2 5
`define CFG_PINCLK1 6
`define CFG_PINCLK2 7

// register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_TERM_ADDR 12'h008
`define REG_TERM_COMMIT 12'h00c
`define REG_TERM_DATA0 12'h010
`define REG_TERM_DATA5 12'h024
`define REG_CFG_BASE 12'h040
`define REG_CFG_LAST 12'h09c
`define REG_Q1 12'h100
`define REG_Q2 12'h104

// reset values
`define CTRL_RESET 32'h00000000
`define CFG_RESET 8'h00

// timing
`define POWERUP_RESET_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define POWERUP_RESET_CYCLES (`POWERUP_RESET_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: src/term_store.v
`timescale 1ns/1ps

// simple dual-port store for product-term masks, registered read
module term_store #(
  parameter WIDTH = 172,
  parameter DEPTH = 416,
  parameter AW = 9
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // no reset on the array itself: software programs every term before running
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// File: src/macrocell_register_pair_preload.v
`timescale 1ns/1ps
`include "macrocell_regs.vh"

// How it works
// RQ1: two flops per macrocell, own clock/reset/sum
// RQ2: each flop selectable as D or T
// RQ3: eight terms on flop 1 sum, four on flop 2, combinable to twelve
// RQ4: buried flop bypass feeds its input back
// RQ5: product-term clock and async reset per flop
// RQ6: each flop may clock from pin instead
// RQ7: each output enabled by own term
// RQ8: eight sync presets over groups of four/two
// RQ9: power-up clears all registers low
// RQ10: tester keeps clocks still during power-up reset
// RQ11: all pins and flop outputs feed array
// RQ12: pin input path separate from register feedback
// RQ13: odd pin level forces selected register
// RQ14: preload clock pulse loads twelve registers
// RQ15: select pins pick flop bank and parity
// RQ16: observe mode shows buried flops on outputs
// RQ17: test modes are plain digital inputs
module macrocell_register_pair_preload (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [13:0] ded_in,
  input wire [23:0] io_in,
  output reg [23:0] io_out,
  output reg [23:0] io_oe,
  input wire preload_mode,
  input wire preload_clk,
  input wire reg_select,
  input wire parity_select,
  input wire observe_mode
);

  localparam [31:0] PU_COUNT = `POWERUP_RESET_CYCLES;
  localparam [7:0] PU_CYCLES = PU_COUNT[7:0];

  // preset group of a macrocell: sizes run 4,2,4,2,... over the 24 cells
  function [2:0] preset_group;
    input integer mc;
    integer g;
    begin
      g = (mc / 6) * 2 + (((mc % 6) >= 4) ? 1 : 0);
      preset_group = g[2:0];
    end
  endfunction

  // apply byte strobes to a register word
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [42:0] pin_meta;
  reg [42:0] pin_sync;
  wire [13:0] ded_s = pin_sync[13:0];
  wire [23:0] io_s = pin_sync[37:14];
  wire pl_mode_s = pin_sync[38];
  wire pl_clk_s = pin_sync[39];
  wire par_s = pin_sync[40];
  wire regsel_s = pin_sync[41];
  wire observe_s = pin_sync[42];
  reg pl_clk_prev;

  // every pin passes two flops; only the second is read
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 43'h0;
      pin_sync <= 43'h0;
      pl_clk_prev <= 1'b0;
    end else begin
      pin_meta <= {observe_mode, reg_select, parity_select, preload_clk, preload_mode, io_in, ded_in};
      pin_sync <= pin_meta;
      pl_clk_prev <= pl_clk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up reset interval

  reg [7:0] pu_cnt;
  reg pu_done;

  // registers held clear and clocks ignored until the interval ends
  always @(posedge aclk) begin
    if (!aresetn) begin
      pu_cnt <= 8'h00;
      pu_done <= 1'b0;
    end else if (!pu_done) begin
      if (pu_cnt == PU_CYCLES - 8'h01) begin
        pu_done <= 1'b1; // RQ10
      end
      pu_cnt <= pu_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side and configuration registers

  reg aw_got;
  reg w_got;
  reg [11:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg [31:0] ctrl;
  reg [8:0] term_addr;
  reg [31:0] term_data [0:5];
  reg [7:0] cfg [0:23];
  reg mem_we;
  wire run = ctrl[0];
  wire [11:0] wr_cfg_off = wr_addr - `REG_CFG_BASE;
  wire wr_is_cfg = (wr_addr >= `REG_CFG_BASE) && (wr_addr <= `REG_CFG_LAST) && (wr_addr[1:0] == 2'h0);
  wire wr_is_data = (wr_addr >= `REG_TERM_DATA0) && (wr_addr <= `REG_TERM_DATA5) && (wr_addr[1:0] == 2'h0);
  wire [11:0] wr_data_off = wr_addr - `REG_TERM_DATA0;
  wire wr_known = wr_is_cfg || wr_is_data || (wr_addr == `REG_CTRL) || (wr_addr == `REG_TERM_ADDR) ||
                  (wr_addr == `REG_TERM_COMMIT);
  // strobed words, cut back to each register's own width where stored
  wire [31:0] term_addr_w = merge({23'h0, term_addr}, wr_data, wr_strb);
  wire [31:0] cfg_w = merge({24'h0, cfg[wr_cfg_off[6:2]]}, wr_data, wr_strb);
  integer k;

  // address and data are taken independently; response once both are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      ctrl <= `CTRL_RESET;
      term_addr <= 9'h000;
      mem_we <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        term_data[k] <= 32'h0;
      end
      for (k = 0; k < `MACROCELLS; k = k + 1) begin
        cfg[k] <= `CFG_RESET;
      end
    end else begin
      mem_we <= 1'b0;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
        if (wr_addr == `REG_CTRL) begin
          ctrl <= merge(ctrl, wr_data, wr_strb) & 32'h00000001;
        end
        if (wr_addr == `REG_TERM_ADDR) begin
          term_addr <= term_addr_w[8:0];
        end
        if (wr_addr == `REG_TERM_COMMIT && term_addr <= `TERM_LAST) begin
          mem_we <= 1'b1;
        end
        if (wr_is_data) begin
          term_data[wr_data_off[4:2]] <= merge(term_data[wr_data_off[4:2]], wr_data, wr_strb);
        end
        if (wr_is_cfg) begin
          cfg[wr_cfg_off[6:2]] <= cfg_w[7:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product-term store and sweep

  reg sweep_busy;
  reg [8:0] issue_idx;
  reg rd_valid;
  reg [8:0] rd_idx;
  reg apply;
  reg [85:0] ain_snap;
  reg [415:0] pt_vec;
  wire [171:0] term_mask;
  wire [171:0] term_wdata = {term_data[5][11:0], term_data[4], term_data[3], term_data[2], term_data[1],
                             term_data[0]};
  wire [85:0] ain;
  wire term_hit = &((~term_mask[85:0] | ain_snap) & (~term_mask[171:86] | ~ain_snap));

  term_store #(
    .WIDTH(`TERM_WIDTH),
    .DEPTH(`TERM_COUNT),
    .AW(9)
  ) u_terms (
    .clk(aclk),
    .we(mem_we),
    .waddr(term_addr),
    .wdata(term_wdata),
    .raddr(issue_idx),
    .rdata(term_mask)
  );

  // one term per cycle; a sweep snapshots the array inputs so all terms see one state
  always @(posedge aclk) begin
    if (!aresetn) begin
      sweep_busy <= 1'b0;
      issue_idx <= 9'h000;
      rd_valid <= 1'b0;
      rd_idx <= 9'h000;
      apply <= 1'b0;
      ain_snap <= 86'h0;
      pt_vec <= 416'h0;
    end else begin
      apply <= 1'b0;
      rd_valid <= 1'b0;
      if (!sweep_busy) begin
        // wait for the previous apply so feedback reflects updated flops
        if (run && pu_done && !rd_valid && !apply) begin
          sweep_busy <= 1'b1;
          issue_idx <= 9'h000;
          ain_snap <= ain; // RQ11
        end
      end else begin
        rd_valid <= 1'b1;
        rd_idx <= issue_idx;
        if (issue_idx == `TERM_LAST) begin
          sweep_busy <= 1'b0;
        end else begin
          issue_idx <= issue_idx + 9'h001;
        end
      end
      if (rd_valid) begin
        pt_vec[rd_idx] <= term_hit;
        if (rd_idx == `TERM_LAST) begin
          apply <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // macrocell logic

  reg [23:0] q1;
  reg [23:0] q2;
  reg [23:0] ck1_prev;
  reg [23:0] ck2_prev;
  wire [23:0] next_q1;
  wire [23:0] next_q2;
  wire [23:0] ck1_v;
  wire [23:0] ck2_v;
  wire [23:0] f2_v;
  wire [23:0] out_v;
  wire [23:0] oe_v;
  wire [23:0] pl_mask;
  wire [23:0] pl_data;
  wire clk_pin = ain_snap[0];

  // dedicated pins, i/o pins, primary flops and buried feedback each own array slots
  assign ain = {f2_v, q1, io_s, ded_s}; // RQ12

  genvar i;
  generate
    for (i = 0; i < `MACROCELLS; i = i + 1) begin : g_mc
      localparam integer B = i * `TERMS_PER_MC;
      wire [16:0] p = pt_vec[B+16:B];
      wire [7:0] c = cfg[i];
      wire s0 = |p[3:0];
      wire s1 = |p[7:4];
      wire s2 = |p[11:8];
      wire pre = pt_vec[`PRESET_BASE + preset_group(i)];
      wire dt1 = c[`CFG_COMBINE] ? (s0 | s1 | s2) : (s0 | s1); // RQ3
      wire dt2 = s2;
      wire rise1;
      wire rise2;
      wire d1;
      wire d2;
      wire norm;
      // pin clock replaces the term clock when selected
      assign ck1_v[i] = c[`CFG_PINCLK1] ? clk_pin : p[`PT_CK1]; // RQ6
      assign ck2_v[i] = c[`CFG_PINCLK2] ? clk_pin : p[`PT_CK2]; // RQ6
      assign rise1 = ck1_v[i] & ~ck1_prev[i]; // RQ5
      assign rise2 = ck2_v[i] & ~ck2_prev[i]; // RQ5
      assign d1 = c[`CFG_T1] ? (q1[i] ^ dt1) : dt1; // RQ2
      assign d2 = c[`CFG_T2] ? (q2[i] ^ dt2) : dt2; // RQ2
      // async reset term wins, then group preset on the clock edge
      assign next_q1[i] = p[`PT_AR1] ? 1'b0 : (rise1 ? (pre | d1) : q1[i]); // RQ1 RQ5 RQ8
      assign next_q2[i] = p[`PT_AR2] ? 1'b0 : (rise2 ? (pre | d2) : q2[i]); // RQ1 RQ5 RQ8
      assign f2_v[i] = c[`CFG_BYPASS] ? dt2 : q2[i]; // RQ4
      assign norm = (c[`CFG_COMBOUT] ? dt1 : q1[i]) ^ ~c[`CFG_POLARITY]; // RQ9
      assign out_v[i] = observe_s ? q2[i] : norm; // RQ16
      assign oe_v[i] = p[`PT_OE]; // RQ7
      // odd pins feed the twelve cells of the chosen parity
      assign pl_mask[i] = ((i % 2) == 1) ? par_s : ~par_s; // RQ15
      assign pl_data[i] = io_s[(i / 2) * 2 + 1]; // RQ13
    end
  endgenerate

  // preload takes over the flops entirely while its mode input is high
  always @(posedge aclk) begin
    if (!aresetn || !pu_done) begin
      q1 <= 24'h0; // RQ9
      q2 <= 24'h0; // RQ9
      ck1_prev <= 24'h0;
      ck2_prev <= 24'h0;
    end else if (pl_mode_s) begin // RQ17
      if (pl_clk_s && !pl_clk_prev) begin // RQ14
        if (!regsel_s) begin
          q1 <= (q1 & ~pl_mask) | (pl_data & pl_mask); // RQ13 RQ15
        end else begin
          q2 <= (q2 & ~pl_mask) | (pl_data & pl_mask); // RQ13 RQ15
        end
      end
    end else if (apply) begin
      q1 <= next_q1;
      q2 <= next_q2;
      ck1_prev <= ck1_v;
      ck2_prev <= ck2_v;
    end
  end

  // outputs registered; drivers released during preload so the tester can drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_out <= 24'h0;
      io_oe <= 24'h0;
    end else begin
      io_out <= out_v;
      io_oe <= pl_mode_s ? 24'h0 : oe_v; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  reg [31:0] rd_mux;
  reg rd_ok;
  wire [11:0] rd_cfg_off = s_axi_araddr - `REG_CFG_BASE;
  wire [11:0] rd_data_off = s_axi_araddr - `REG_TERM_DATA0;

  // read decode; unmapped words answer slverr with zero data
  always @* begin
    rd_mux = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr >= `REG_CFG_BASE && s_axi_araddr <= `REG_CFG_LAST && s_axi_araddr[1:0] == 2'h0) begin
      rd_mux = {24'h0, cfg[rd_cfg_off[6:2]]};
    end else if (s_axi_araddr >= `REG_TERM_DATA0 && s_axi_araddr <= `REG_TERM_DATA5 &&
                 s_axi_araddr[1:0] == 2'h0) begin
      rd_mux = term_data[rd_data_off[4:2]];
    end else begin
      case (s_axi_araddr)
        `REG_CTRL: rd_mux = ctrl;
        `REG_STATUS: rd_mux = {27'h0, observe_s, pl_mode_s, apply, sweep_busy, pu_done};
        `REG_TERM_ADDR: rd_mux = {23'h0, term_addr};
        `REG_TERM_COMMIT: rd_mux = 32'h0;
        `REG_Q1: rd_mux = {8'h0, q1};
        `REG_Q2: rd_mux = {8'h0, q2};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // one read at a time, answered the cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: tb/pin_checker_assertions.sv
`timescale 1ns/1ps

// watches the pins and the register bus of the macrocell block
module pin_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [23:0] io_out,
  input wire [23:0] io_oe,
  input wire preload_mode,
  input wire preload_clk,
  input wire observe_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////
  // reset and power-up levels; outputs still show the reset values at release
  chk_reset_outs: assert property ($rose(aresetn) |-> io_oe == 24'h0 && io_out == 24'h0 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  chk_powerup_out: assert property ($rose(aresetn) && !observe_mode |=> (io_out == 24'hffffff) [*8])
    else $error("outputs not at cleared level after power-up");
  // synced test mode needs three edges before the enables drop
  chk_oe_preload: assert property (preload_mode [*4] |-> io_oe == 24'h0)
    else $error("output enable active during preload");

  ////////////////////////////////////////////////////////////////
  // register bus handshakes
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write offered while response pending");
  chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read offered while data pending");

  cov_preload: cover property (preload_mode && $rose(preload_clk));
  cov_observe: cover property (observe_mode && io_out != 24'h0);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind macrocell_register_pair_preload pin_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .io_out(io_out), .io_oe(io_oe),
  .preload_mode(preload_mode), .preload_clk(preload_clk), .observe_mode(observe_mode)
);

// File: tb/pin_tester.sv
`timescale 1ns/1ps

// board and tester side of the pins
module pin_tester (
  input wire aclk,
  input wire [23:0] io_out,
  input wire [23:0] io_oe,
  output logic [13:0] ded_in,
  output wire [23:0] io_in,
  output logic preload_clk
);
  logic [23:0] drive;

  // pins driven by the device win, the tester fills the rest
  assign io_in = (io_oe & io_out) | (~io_oe & drive);

  // clock pin and clock-term sources start low and stay still through power-up, so power-up stays clean
  initial begin
    ded_in = 14'h0;
    drive = 24'h0;
    preload_clk = 1'b0;
  end

  // logic inputs and clock pin; only moved once power-up is long over
  task set_ded(input logic [13:0] v);
    @(posedge aclk);
    ded_in <= v;
  endtask

  task set_pins(input logic [23:0] v);
    @(posedge aclk);
    drive <= v;
  endtask

  // wide pulse so the synced edge is seen with data settled
  task pulse_preload;
    repeat (4) @(posedge aclk);
    preload_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    preload_clk <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// File: tb/macrocell_register_pair_preload_tb.sv
`timescale 1ns/1ps
`include "macrocell_regs.vh"

module macrocell_register_pair_preload_tb;
  logic aclk;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic preload_mode = 1'b0;
  logic reg_select = 1'b0;
  logic parity_select = 1'b0;
  logic observe_mode = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, preload_clk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [13:0] ded_in;
  wire [23:0] io_in, io_out, io_oe;
  int miscompares = 0;
  int compares = 0;
  logic [23:0] exp_q1 = 24'h0;
  logic [23:0] exp_q2 = 24'h0;

  macrocell_register_pair_preload u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ded_in(ded_in),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .preload_mode(preload_mode),
    .preload_clk(preload_clk), .reg_select(reg_select), .parity_select(parity_select),
    .observe_mode(observe_mode)
  );

  pin_tester u_tester (.aclk(aclk), .io_out(io_out), .io_oe(io_oe), .ded_in(ded_in), .io_in(io_in),
    .preload_clk(preload_clk));

  // free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////
  // shared checks and bus cycles
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // both channels offered together, each dropped on its own handshake
  task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task read_check(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task t_powerup;
    repeat (2) @(posedge aclk);
    #1 check({8'h0, io_out}, 32'h00ffffff);
    read_check(`REG_STATUS, 32'h0, 2'b00);
    repeat (110) @(posedge aclk);
    read_check(`REG_STATUS, 32'h1, 2'b00);
    read_check(`REG_Q1, 32'h0, 2'b00);
    read_check(`REG_Q2, 32'h0, 2'b00);
  endtask

  // run stays off: the term store holds no programmed masks
  task t_regs;
    axi_write(`REG_CTRL, 32'h0, 2'b00);
    read_check(`REG_CTRL, `CTRL_RESET, 2'b00);
    read_check(`REG_CFG_BASE, {24'h0, `CFG_RESET}, 2'b00);
    axi_write(`REG_TERM_ADDR, 32'hffffffff, 2'b00);
    read_check(`REG_TERM_ADDR, 32'h000001ff, 2'b00);
    axi_write(`REG_CFG_LAST, 32'h000000a5, 2'b00);
    read_check(`REG_CFG_LAST, 32'h000000a5, 2'b00);
    axi_write(`REG_CFG_LAST, 32'h0, 2'b00);
    axi_write(12'hffc, 32'hffffffff, 2'b10);
    read_check(12'hffc, 32'h0, 2'b10);
  endtask

  // every bank and parity once, each pattern different
  task t_preload;
    int j;
    int k;
    logic [23:0] pat;
    @(posedge aclk);
    preload_mode <= 1'b1;
    repeat (5) @(posedge aclk);
    #1 check({8'h0, io_oe}, 32'h0);
    for (k = 0; k < 4; k++) begin
      pat = {3{8'h5a ^ (8'h27 * k[7:0])}};
      @(posedge aclk);
      reg_select <= k[1];
      parity_select <= k[0];
      u_tester.set_pins(pat);
      u_tester.pulse_preload();
      for (j = 0; j < 12; j++) begin
        if (k[1]) exp_q2[2 * j + k[0]] = pat[2 * j + 1];
        else exp_q1[2 * j + k[0]] = pat[2 * j + 1];
      end
      read_check(`REG_Q1, {8'h0, exp_q1}, 2'b00);
      read_check(`REG_Q2, {8'h0, exp_q2}, 2'b00);
    end
  endtask

  task t_observe;
    @(posedge aclk);
    preload_mode <= 1'b0;
    observe_mode <= 1'b1;
    repeat (5) @(posedge aclk);
    #1 check({8'h0, io_out}, {8'h0, exp_q2});
    @(posedge aclk);
    observe_mode <= 1'b0;
    repeat (5) @(posedge aclk);
    #1 check({8'h0, io_out}, {8'h0, ~exp_q1});
  endtask

  // every term never true except cell 0's first d term and its oe;
  // cell 0 primary is a t flop on the pin clock, so one rise toggles it once
  task t_array;
    int t;
    axi_write(`REG_TERM_DATA0, 32'h00000002, 2'b00);
    axi_write(`REG_TERM_DATA0 + 12'h008, 32'h00800000, 2'b00);
    for (t = 0; t < `TERM_COUNT; t++) begin
      axi_write(`REG_TERM_ADDR, t, 2'b00);
      axi_write(`REG_TERM_COMMIT, 32'h0, 2'b00);
    end
    axi_write(`REG_TERM_DATA0, 32'h0, 2'b00);
    axi_write(`REG_TERM_DATA0 + 12'h008, 32'h0, 2'b00);
    axi_write(`REG_TERM_ADDR, 32'h0, 2'b00);
    axi_write(`REG_TERM_COMMIT, 32'h0, 2'b00);
    axi_write(`REG_TERM_ADDR, `PT_OE, 2'b00);
    axi_write(`REG_TERM_COMMIT, 32'h0, 2'b00);
    axi_write(`REG_CFG_BASE, 32'h00000050, 2'b00);
    axi_write(`REG_CTRL, 32'h00000001, 2'b00);
    repeat (900) @(posedge aclk);
    read_check(`REG_Q1, {8'h0, exp_q1}, 2'b00);
    read_check(`REG_Q2, {8'h0, exp_q2}, 2'b00);
    check({8'h0, io_oe}, 32'h00000001);
    u_tester.set_ded(14'h0001);
    repeat (900) @(posedge aclk);
    exp_q1[0] = ~exp_q1[0];
    read_check(`REG_Q1, {8'h0, exp_q1}, 2'b00);
    check({8'h0, io_out}, {8'h0, ~exp_q1});
    u_tester.set_ded(14'h0000);
    repeat (900) @(posedge aclk);
    read_check(`REG_Q1, {8'h0, exp_q1}, 2'b00);
  endtask

  // a second reset in mid-run clears the preloaded state again
  task t_rerun;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (110) @(posedge aclk);
    read_check(`REG_Q1, 32'h0, 2'b00);
    read_check(`REG_Q2, 32'h0, 2'b00);
  endtask

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_powerup();
    t_regs();
    t_preload();
    t_observe();
    t_array();
    t_rerun();
    final_report();
  end

  // whole run is under 8000 cycles, so this only fires on a hang
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
